// ---- hw/lds_map.svh ----
`ifndef LDS_MAP_SVH
`define LDS_MAP_SVH

// command codes of the register bank
`define LDS_CODE_BIAS_DAC 8'h01
`define LDS_CODE_MOD_DAC 8'h02
`define LDS_CODE_POWER_CEILING 8'h03
`define LDS_CODE_INT_TEMP 8'h05
`define LDS_CODE_MOD_READING 8'h06
`define LDS_CODE_BIAS_READING 8'h07
`define LDS_CODE_TEST_RSVD 8'h08
`define LDS_CODE_EXT_TEMP 8'h0D
`define LDS_CODE_SYS_SETUP 8'h10
`define LDS_CODE_BIAS_CEILING 8'h11
`define LDS_CODE_FAULT_STATE 8'h12
`define LDS_CODE_FAULT_SETUP 8'h13
`define LDS_CODE_BIAS_NOMINAL 8'h15
`define LDS_CODE_BIAS_TC1 8'h16
`define LDS_CODE_BIAS_TC2 8'h17
`define LDS_CODE_USER_CONV 8'h18
`define LDS_CODE_MOD_NOMINAL 8'h19
`define LDS_CODE_MOD_TC1 8'h1A
`define LDS_CODE_MOD_TC2 8'h1B
`define LDS_CODE_NOMINAL_TEMP 8'h1D
`define LDS_CODE_SERVO_GAIN 8'h1E
`define LDS_CODE_PEAKING 8'h1F

// system setup field positions
`define LDS_BIT_CML_TERM 7
`define LDS_BIT_DIODE_POL 6
`define LDS_BIT_EXT_TEMP 5
`define LDS_BIT_PWR_DOWN 4
`define LDS_BIT_APC 3
`define LDS_BIT_GATE_POL 2
`define LDS_BIT_SOFT_EN 1
`define LDS_BIT_HOST_CTRL 0

// system setup reset value and writable mask
`define LDS_SYS_RESET 16'h0010
`define LDS_SYS_MASK 16'h00FF

// eeprom retry interval
`define LDS_RETRY_MS 64
`define LDS_CLK_MHZ 100

`endif

// ---- hw/lds_pin_sync.sv ----
`timescale 1ns/10ps
`default_nettype none

// three-stage pin synchroniser with agreement filter
module lds_pin_sync (
  input wire logic i_ref_clk,
  input wire logic i_rstn,
  input wire logic i_pin,
  output logic o_level
);

  logic [2:0] stage; // stage[0] is read only by stage[1]

  // shift chain, resets low
  always_ff @(posedge i_ref_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      stage <= 3'h0;
    end else begin
      stage <= {stage[1:0], i_pin};
    end
  end

  // a change counts only once stages two and three agree
  wire agree = (stage[1] == stage[2]);

  always_ff @(posedge i_ref_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_level <= 1'b0;
    end else if (agree) begin
      o_level <= stage[2];
    end
  end

endmodule

`default_nettype wire

// ---- hw/lds_pkg.sv ----
`default_nettype none

package lds_pkg;

  // one command code byte
  typedef logic [7:0] lds_code_t;

  // one register word
  typedef logic [15:0] lds_word_t;

  // eeprom load sequencer, gray along wait -> busy -> done
  typedef enum logic [1:0] {
    LDS_LD_WAIT = 2'b00,
    LDS_LD_BUSY = 2'b01,
    LDS_LD_DONE = 2'b11
  } lds_load_state_t;

endpackage

`default_nettype wire

// ---- hw/lds_reg_mem.sv ----
`timescale 1ns/10ps
`default_nettype none

// 32 x 16 storage for the plain read/write registers
module lds_reg_mem (
  input wire logic i_ref_clk,
  input wire logic i_rstn,
  input wire logic i_we,
  input wire logic [4:0] i_waddr,
  input wire logic [15:0] i_wdata,
  input wire logic [4:0] i_raddr,
  output logic [15:0] o_rdata
);

  logic [15:0] mem [0:31]; // cleared at reset so reads are never unknown

  // write port; reset clears every word
  always_ff @(posedge i_ref_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      for (int i = 0; i < 32; i++) begin
        mem[i] <= 16'h0000;
      end
    end else if (i_we) begin
      mem[i_waddr] <= i_wdata;
    end
  end

  // registered read, old data on a same-cycle write
  always_ff @(posedge i_ref_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_rdata <= 16'h0000;
    end else begin
      o_rdata <= mem[i_raddr];
    end
  end

endmodule

`default_nettype wire

// ---- hw/lds_regs.sv ----
// What this block does
// - one-byte codes select registers; some read-only
// - bit 7 selects input termination style
// - bit 6 sets monitor photodiode polarity
// - bit 5 picks internal or host temperature
// - bit 4 powers down amplifiers while disabled
// - bit 3 picks constant bias or APC
// - bit 2 sets transmit gate pin polarity
// - bit 1 is software transmit enable
// - transmit needs gate active and soft enable
// - bit 0 picks standalone or host control
// - setup resets to zero except bit 4
// - standalone retries eeprom load every 64ms
`include "lds_map.svh"
`timescale 1ns/10ps
`default_nettype none

module lds_regs #(
  // retry interval in cycles; shorten for simulation
  parameter int unsigned RETRY_CYCLES = `LDS_RETRY_MS * 1000 * `LDS_CLK_MHZ
) (
  input wire logic i_ref_clk,
  input wire logic i_rstn,
  // command port from the serial front end or the eeprom loader
  input wire logic [7:0] i_cmd_code,
  input wire logic i_wr_stb,
  input wire logic [15:0] i_wr_data,
  input wire logic i_rd_stb,
  output logic [15:0] o_rd_data,
  output logic o_rd_valid,
  output logic o_wr_ack,
  output logic o_cmd_err,
  // live values for the read-only registers
  input wire logic [15:0] i_fault_state,
  input wire logic [15:0] i_power_ceiling,
  // transmit gate pin, asynchronous
  input wire logic i_tx_gate_pin,
  // eeprom loader handshake
  input wire logic i_load_ok,
  input wire logic i_load_fail,
  output logic o_load_start,
  output logic o_load_busy,
  output logic o_load_done,
  // configuration outputs
  output logic [15:0] o_sys_setup,
  output logic o_cml_termination,
  output logic o_monitor_diode_polarity,
  output logic o_ext_temp_sel,
  output logic o_apc_mode,
  output logic o_host_control,
  output logic o_tx_enable,
  output logic o_hs_amp_off
);

  // ---------------------------------------------------------------
  // decoding helpers, used for both read and write paths
  // ---------------------------------------------------------------

  // true for every code that names a register
  function automatic logic lds_is_mapped(input lds_pkg::lds_code_t code);
    case (code)
      `LDS_CODE_BIAS_DAC, `LDS_CODE_MOD_DAC, `LDS_CODE_POWER_CEILING,
      `LDS_CODE_INT_TEMP, `LDS_CODE_MOD_READING, `LDS_CODE_BIAS_READING,
      `LDS_CODE_TEST_RSVD, `LDS_CODE_EXT_TEMP, `LDS_CODE_SYS_SETUP,
      `LDS_CODE_BIAS_CEILING, `LDS_CODE_FAULT_STATE, `LDS_CODE_FAULT_SETUP,
      `LDS_CODE_BIAS_NOMINAL, `LDS_CODE_BIAS_TC1, `LDS_CODE_BIAS_TC2,
      `LDS_CODE_USER_CONV, `LDS_CODE_MOD_NOMINAL, `LDS_CODE_MOD_TC1,
      `LDS_CODE_MOD_TC2, `LDS_CODE_NOMINAL_TEMP, `LDS_CODE_SERVO_GAIN,
      `LDS_CODE_PEAKING: lds_is_mapped = 1'b1;
      default: lds_is_mapped = 1'b0;
    endcase
  endfunction

  // mapped codes minus the two read-only ones
  function automatic logic lds_is_writable(input lds_pkg::lds_code_t code);
    lds_is_writable = lds_is_mapped(code) &&
                      (code != `LDS_CODE_POWER_CEILING) &&
                      (code != `LDS_CODE_FAULT_STATE);
  endfunction

  // ---------------------------------------------------------------
  // reset release: async assert, two-flop synchronous release
  // ---------------------------------------------------------------
  logic [1:0] rst_pipe; // release shift register
  wire rstn_sync = rst_pipe[1]; // reset used by all other logic

  always_ff @(posedge i_ref_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      rst_pipe <= 2'b00;
    end else begin
      rst_pipe <= {rst_pipe[0], 1'b1};
    end
  end

  // ---------------------------------------------------------------
  // command decode
  // ---------------------------------------------------------------
  wire code_mapped = lds_is_mapped(i_cmd_code); // any known code
  wire code_writable = lds_is_writable(i_cmd_code); // writes land
  wire wr_setup = i_wr_stb && (i_cmd_code == `LDS_CODE_SYS_SETUP); // setup word
  wire wr_mem = i_wr_stb && code_writable && !wr_setup; // storage words
  wire wr_refused = i_wr_stb && !code_writable; // read-only or unknown
  wire rd_refused = i_rd_stb && !code_mapped; // unknown code read

  // ---------------------------------------------------------------
  // system setup register
  // ---------------------------------------------------------------
  lds_pkg::lds_word_t sys_setup; // only the low byte is storage
  wire [15:0] next_sys_setup = i_wr_data & `LDS_SYS_MASK;

  // write path; reserved high byte never stored
  always_ff @(posedge i_ref_clk or negedge rstn_sync) begin
    if (!rstn_sync) begin
      sys_setup <= `LDS_SYS_RESET;
    end else if (wr_setup) begin
      sys_setup <= next_sys_setup;
    end
  end

  // field views of the setup word
  wire cfg_cml = sys_setup[`LDS_BIT_CML_TERM];
  wire cfg_diode_pol = sys_setup[`LDS_BIT_DIODE_POL];
  wire cfg_ext_temp = sys_setup[`LDS_BIT_EXT_TEMP];
  wire cfg_pwr_down = sys_setup[`LDS_BIT_PWR_DOWN];
  wire cfg_apc = sys_setup[`LDS_BIT_APC];
  wire cfg_gate_pol = sys_setup[`LDS_BIT_GATE_POL];
  wire cfg_soft_en = sys_setup[`LDS_BIT_SOFT_EN];
  wire cfg_host = sys_setup[`LDS_BIT_HOST_CTRL];

  // ---------------------------------------------------------------
  // storage for the other registers
  // ---------------------------------------------------------------
  logic [15:0] mem_rdata; // valid one cycle after a read strobe

  lds_reg_mem u_mem (
    .i_ref_clk(i_ref_clk),
    .i_rstn(rstn_sync),
    .i_we(wr_mem),
    .i_waddr(i_cmd_code[4:0]),
    .i_wdata(i_wr_data),
    .i_raddr(i_cmd_code[4:0]),
    .o_rdata(mem_rdata)
  );

  // ---------------------------------------------------------------
  // read pipeline: strobe -> memory word -> output register
  // ---------------------------------------------------------------
  lds_pkg::lds_code_t rd_code; // code held while memory reads
  logic rd_pend; // a read is in flight
  logic rd_bad; // the read in flight hit no register

  // capture the code so the mux knows the source next cycle
  always_ff @(posedge i_ref_clk or negedge rstn_sync) begin
    if (!rstn_sync) begin
      rd_code <= 8'h00;
      rd_pend <= 1'b0;
      rd_bad <= 1'b0;
    end else begin
      rd_pend <= i_rd_stb;
      rd_bad <= rd_refused;
      if (i_rd_stb) begin
        rd_code <= i_cmd_code;
      end
    end
  end

  // source selection; read-only words sampled live
  wire sel_setup = (rd_code == `LDS_CODE_SYS_SETUP);
  wire sel_fault = (rd_code == `LDS_CODE_FAULT_STATE);
  wire sel_ceiling = (rd_code == `LDS_CODE_POWER_CEILING);
  wire [15:0] rd_mux = rd_bad ? 16'h0000 :
                       sel_setup ? (sys_setup & `LDS_SYS_MASK) :
                       sel_fault ? i_fault_state :
                       sel_ceiling ? i_power_ceiling :
                       mem_rdata;

  // output register; data holds until the next read completes
  always_ff @(posedge i_ref_clk or negedge rstn_sync) begin
    if (!rstn_sync) begin
      o_rd_data <= 16'h0000;
      o_rd_valid <= 1'b0;
    end else begin
      o_rd_valid <= rd_pend;
      if (rd_pend) begin
        o_rd_data <= rd_mux;
      end
    end
  end

  // write acknowledge and error pulses, one cycle after the strobe
  always_ff @(posedge i_ref_clk or negedge rstn_sync) begin
    if (!rstn_sync) begin
      o_wr_ack <= 1'b0;
      o_cmd_err <= 1'b0;
    end else begin
      o_wr_ack <= i_wr_stb && code_writable;
      o_cmd_err <= wr_refused || rd_refused;
    end
  end

  // ---------------------------------------------------------------
  // transmit gate and enable
  // ---------------------------------------------------------------
  logic gate_level; // filtered pin level

  lds_pin_sync u_gate_sync (
    .i_ref_clk(i_ref_clk),
    .i_rstn(rstn_sync),
    .i_pin(i_tx_gate_pin),
    .o_level(gate_level)
  );

  // polarity applied before the and with the soft enable
  wire gate_active = cfg_gate_pol ? gate_level : !gate_level;
  wire next_tx_enable = gate_active && cfg_soft_en;

  // registered enable so the output is glitch free
  always_ff @(posedge i_ref_clk or negedge rstn_sync) begin
    if (!rstn_sync) begin
      o_tx_enable <= 1'b0;
    end else begin
      o_tx_enable <= next_tx_enable;
    end
  end

  // registered configuration outputs
  always_ff @(posedge i_ref_clk or negedge rstn_sync) begin
    if (!rstn_sync) begin
      o_cml_termination <= 1'b0;
      o_monitor_diode_polarity <= 1'b0;
      o_ext_temp_sel <= 1'b0;
      o_apc_mode <= 1'b0;
      o_host_control <= 1'b0;
      o_hs_amp_off <= 1'b0;
    end else begin
      o_cml_termination <= cfg_cml;
      o_monitor_diode_polarity <= cfg_diode_pol;
      o_ext_temp_sel <= cfg_ext_temp;
      o_apc_mode <= cfg_apc;
      o_host_control <= cfg_host;
      // amplifiers off only while disabled and saving is allowed
      o_hs_amp_off <= cfg_pwr_down && !next_tx_enable;
    end
  end

  assign o_sys_setup = sys_setup; // flop output, high byte always zero

  // ---------------------------------------------------------------
  // eeprom load sequencer
  // ---------------------------------------------------------------
  // counter starts at zero so the first attempt follows reset at once
  lds_pkg::lds_load_state_t ld_state;
  lds_pkg::lds_load_state_t next_ld_state;
  logic [31:0] retry_cnt; // cycles until the next attempt
  logic [31:0] next_retry_cnt;
  logic next_load_start;
  wire standalone = !cfg_host; // host control halts retries
  wire retry_due = (retry_cnt == 32'h0000_0000);

  // next-state logic
  always_comb begin
    next_ld_state = ld_state;
    next_retry_cnt = retry_cnt;
    next_load_start = 1'b0;
    case (ld_state)
      lds_pkg::LDS_LD_WAIT: begin
        if (!standalone) begin
          // parked; the bit may be cleared again later
          next_retry_cnt = 32'h0000_0000;
        end else if (retry_due) begin
          next_load_start = 1'b1;
          next_ld_state = lds_pkg::LDS_LD_BUSY;
          next_retry_cnt = RETRY_CYCLES - 32'h0000_0001;
        end else begin
          next_retry_cnt = retry_cnt - 32'h0000_0001;
        end
      end
      lds_pkg::LDS_LD_BUSY: begin
        // interval keeps counting while the loader works
        if (!retry_due) begin
          next_retry_cnt = retry_cnt - 32'h0000_0001;
        end
        if (i_load_ok) begin
          next_ld_state = lds_pkg::LDS_LD_DONE;
        end else if (i_load_fail) begin
          next_ld_state = lds_pkg::LDS_LD_WAIT;
        end
      end
      lds_pkg::LDS_LD_DONE: begin
        // success is final until the next reset
        next_retry_cnt = 32'h0000_0000;
      end
      default: begin
        next_ld_state = lds_pkg::LDS_LD_WAIT;
        next_retry_cnt = 32'h0000_0000;
      end
    endcase
  end

  // sequencer registers
  always_ff @(posedge i_ref_clk or negedge rstn_sync) begin
    if (!rstn_sync) begin
      ld_state <= lds_pkg::LDS_LD_WAIT;
      retry_cnt <= 32'h0000_0000;
      o_load_start <= 1'b0;
    end else begin
      ld_state <= next_ld_state;
      retry_cnt <= next_retry_cnt;
      o_load_start <= next_load_start;
    end
  end

  assign o_load_busy = (ld_state == lds_pkg::LDS_LD_BUSY);
  assign o_load_done = (ld_state == lds_pkg::LDS_LD_DONE);

endmodule

`default_nettype wire

// ---- test/laser_driver_system_config_regs_bench.sv ----
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin miscompares++; $display("ERROR %s exp %h got %h", nm, e, g); end end

module laser_driver_system_config_regs_bench;
  localparam int RETRY = 50; // short retry interval for simulation
  logic clk, rstn, wr, rd, pin, ok, fail;
  logic [7:0] code;
  logic [15:0] wdat, flt, pwr, rdat, setup, exp_d;
  logic rv, ack, err, lst, ldone, busy, cml, mdp, ets, apc, hst, txe, amp;
  logic [1:0] exp_r;
  logic [31:0] fails; // loader attempts to fail
  int n_starts, cycles, miscompares, n_tests;
  logic [15:0] model [32]; // expected register contents
  logic [15:0] rd_q [$]; // expected read data
  logic [1:0] rsp_q [$]; // expected {ack, err}

  lds_regs #(.RETRY_CYCLES(RETRY)) dut (
    .i_ref_clk(clk), .i_rstn(rstn), .i_cmd_code(code), .i_wr_stb(wr),
    .i_wr_data(wdat), .i_rd_stb(rd), .o_rd_data(rdat), .o_rd_valid(rv),
    .o_wr_ack(ack), .o_cmd_err(err), .i_fault_state(flt), .i_power_ceiling(pwr),
    .i_tx_gate_pin(pin), .i_load_ok(ok), .i_load_fail(fail), .o_load_start(lst),
    .o_load_busy(busy), .o_load_done(ldone), .o_sys_setup(setup), .o_cml_termination(cml),
    .o_monitor_diode_polarity(mdp), .o_ext_temp_sel(ets), .o_apc_mode(apc),
    .o_host_control(hst), .o_tx_enable(txe), .o_hs_amp_off(amp));

  lds_loader_model u_loader (.i_ref_clk(clk), .i_load_start(lst), .i_fails(fails),
    .o_load_ok(ok), .o_load_fail(fail));

  initial clk = 1'b0;
  always #5 clk = ~clk;

  // hang guard
  always @(posedge clk) begin
    cycles++;
    if (cycles == 5000) begin
      miscompares++;
      report_and_stop();
    end
  end

  // result watcher: oldest note against each answer
  always @(posedge clk) begin
    if (lst === 1'b1) n_starts++;
    if (rv === 1'b1) begin exp_d = rd_q.pop_front(); `CHK("rd_data", exp_d, rdat) end
    if ((ack | err) === 1'b1) begin exp_r = rsp_q.pop_front(); `CHK("ack_err", exp_r, {ack, err}) end
  end

  // 2 read/write, 1 read-only, 0 unmapped
  function automatic int kind(input logic [7:0] c);
    case (c)
      8'h03, 8'h12: return 1;
      8'h01, 8'h02, 8'h05, 8'h06, 8'h07, 8'h08, 8'h0D, 8'h10, 8'h11, 8'h13, 8'h15,
      8'h16, 8'h17, 8'h18, 8'h19, 8'h1A, 8'h1B, 8'h1D, 8'h1E, 8'h1F: return 2;
      default: return 0;
    endcase
  endfunction

  // one command per cycle; leaves strobes up for back-to-back use
  task automatic op(input logic w, input logic [7:0] c, input logic [15:0] d);
    int k;
    k = kind(c);
    wr = w;
    rd = !w;
    code = c;
    wdat = d;
    if (w && k == 2) begin
      model[c[4:0]] = (c == 8'h10) ? (d & 16'h00ff) : d;
      rsp_q.push_back(2'b10);
    end else if (w) begin
      rsp_q.push_back(2'b01);
    end else begin
      rd_q.push_back(k == 2 ? model[c[4:0]] : k == 1 ? (c == 8'h03 ? pwr : flt) : 16'h0000);
      if (k == 0) rsp_q.push_back(2'b01);
    end
    @(posedge clk);
    #1;
  endtask

  task automatic idle(input int n);
    wr = 1'b0;
    rd = 1'b0;
    repeat (n) @(posedge clk);
    #1;
  endtask

  // reset held 3 cycles; storage words expected back at zero
  task automatic do_reset();
    foreach (model[i]) model[i] = 16'h0000;
    model[16] = 16'h0010;
    rstn = 1'b0;
    repeat (3) @(posedge clk);
    #1;
    rstn = 1'b1;
    repeat (3) @(posedge clk);
    #1;
  endtask

  task automatic report_and_stop();
    if (miscompares == 0 && n_tests > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  initial begin
    rstn = 1'b0;
    wr = 1'b0;
    rd = 1'b0;
    code = 8'h00;
    wdat = 16'h0000;
    pin = 1'b0;
    fails = 2;
    n_starts = 0;
    cycles = 0;
    miscompares = 0;
    n_tests = 0;
    void'($urandom(32'h1e86));
    flt = 16'($urandom);
    pwr = 16'($urandom);
    do_reset();
    `CHK("setup_rst", 16'h0010, setup)
    // two failed loads then success, retries spaced by the interval
    idle(3 * RETRY + 40);
    `CHK("load_done", 1'b1, ldone)
    `CHK("starts", 3, n_starts)
    `CHK("amp_off_rst", 1'b1, amp)
    // every code from 0x00 to 0x21 written then read, back to back
    for (int c = 0; c < 34; c++) op(1'b1, c[7:0], 16'($urandom));
    for (int c = 0; c < 34; c++) op(1'b0, c[7:0], 16'h0000);
    idle(4);
    // one setup bit at a time onto the field outputs
    for (int b = 0; b < 8; b++) begin
      op(1'b1, 8'h10, 16'h0001 << b);
      idle(3);
      `CHK("fields", {b == 7, b == 6, b == 5, b == 3, b == 0}, {cml, mdp, ets, apc, hst})
    end
    // gate pin, polarity, soft enable and power-down, all combinations
    for (int i = 0; i < 16; i++) begin
      op(1'b1, 8'h10, 16'({i[3], 1'b0, i[2], i[1], 1'b0}));
      pin = i[0];
      idle(8);
      `CHK("tx_en", i[1] & (i[0] == i[2]), txe)
      `CHK("amp_off", i[3] & !(i[1] & (i[0] == i[2])), amp)
    end
    // host control stops retries, clearing it resumes at once
    fails = 1000;
    n_starts = 0;
    do_reset();
    op(1'b1, 8'h10, 16'h0011);
    idle(3 * RETRY);
    `CHK("host_starts", 1, n_starts)
    op(1'b1, 8'h10, 16'h0010);
    idle(2);
    // attempt outstanding until the loader answers, three cycles on
    `CHK("busy", 1'b1, busy)
    idle(8);
    `CHK("resume", 2, n_starts)
    `CHK("busy_end", 1'b0, busy)
    // every noted answer must have been seen by the watcher
    `CHK("pending", 0, rd_q.size() + rsp_q.size())
    report_and_stop();
  end
endmodule

`default_nettype wire

// ---- test/lds_loader_model.sv ----
`timescale 1ns/10ps
`default_nettype none

// eeprom loader stand-in: answers each attempt three cycles late
module lds_loader_model (
  input wire logic i_ref_clk,
  input wire logic i_load_start,
  input wire logic [31:0] i_fails,
  output logic o_load_ok,
  output logic o_load_fail
);
  int unsigned used = 0; // attempts answered so far

  // fails the first i_fails attempts, then succeeds
  initial begin
    o_load_ok = 1'b0;
    o_load_fail = 1'b0;
    forever begin
      @(posedge i_ref_clk);
      if (i_load_start === 1'b1) begin
        repeat (3) @(posedge i_ref_clk);
        #1;
        if (used < i_fails) o_load_fail = 1'b1;
        else o_load_ok = 1'b1;
        used++;
        @(posedge i_ref_clk);
        #1;
        o_load_ok = 1'b0;
        o_load_fail = 1'b0;
      end
    end
  end
endmodule

`default_nettype wire

// ---- test/lds_regs_asserts.sv ----
`timescale 1ns/10ps
`default_nettype none

// watches the register bank ports only
module lds_regs_asserts #(
  parameter int unsigned RETRY_CYCLES = 50
) (
  input wire logic i_ref_clk,
  input wire logic i_rstn,
  input wire logic [7:0] i_cmd_code,
  input wire logic i_wr_stb,
  input wire logic [15:0] i_wr_data,
  input wire logic i_rd_stb,
  input wire logic o_rd_valid,
  input wire logic o_wr_ack,
  input wire logic o_cmd_err,
  input wire logic [15:0] o_sys_setup,
  input wire logic o_cml_termination,
  input wire logic o_monitor_diode_polarity,
  input wire logic o_ext_temp_sel,
  input wire logic o_apc_mode,
  input wire logic o_host_control,
  input wire logic o_tx_enable,
  input wire logic o_hs_amp_off,
  input wire logic o_load_start,
  input wire logic o_load_done
);
  int unsigned gap; // cycles since last load attempt
  logic seen; // an attempt happened since reset

  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (!i_rstn);

  // gap counter saturates, so long idle spells never wrap it
  always_ff @(posedge i_ref_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      gap <= 0;
      seen <= 1'b0;
    end else if (o_load_start) begin
      gap <= 1;
      seen <= 1'b1;
    end else if (gap < RETRY_CYCLES) begin
      gap <= gap + 1;
    end
  end

  a_rd_latency: assert property (o_rd_valid == $past(i_rd_stb, 2))
    else $error("read answer not two cycles after strobe");
  a_wr_answer: assert property (i_wr_stb |=> o_wr_ack != o_cmd_err)
    else $error("write without exactly one answer");
  a_ro_refused: assert property (
    i_wr_stb && (i_cmd_code == 8'h03 || i_cmd_code == 8'h12) |=> o_cmd_err && $stable(o_sys_setup))
    else $error("read-only write not refused");
  a_setup_store: assert property (
    i_wr_stb && i_cmd_code == 8'h10 |=> o_sys_setup == {8'h00, $past(i_wr_data[7:0])})
    else $error("setup word not stored");
  a_rsvd_zero: assert property (o_sys_setup[15:8] == 8'h00)
    else $error("reserved setup bits set");
  a_field_copy: assert property (
    {o_cml_termination, o_monitor_diode_polarity, o_ext_temp_sel, o_apc_mode, o_host_control}
    == $past({o_sys_setup[7], o_sys_setup[6], o_sys_setup[5], o_sys_setup[3], o_sys_setup[0]}))
    else $error("config outputs differ from setup");
  a_tx_gating: assert property (
    o_tx_enable |-> o_sys_setup[1] || $past(o_sys_setup[1]))
    else $error("transmit on without soft enable");
  a_amp_off: assert property (
    o_hs_amp_off |-> !o_tx_enable && (o_sys_setup[4] || $past(o_sys_setup[4])))
    else $error("amplifiers off at wrong time");
  a_host_quiet: assert property (
    o_host_control && $past(o_host_control) |-> !o_load_start)
    else $error("load attempt under host control");
  a_retry_gap: assert property (o_load_start && seen |-> gap >= RETRY_CYCLES)
    else $error("load retry too early");
  a_done_final: assert property (o_load_done |=> o_load_done && !o_load_start)
    else $error("load retried after success");
endmodule

bind lds_regs lds_regs_asserts #(.RETRY_CYCLES(RETRY_CYCLES)) u_chk (
  .i_ref_clk(i_ref_clk), .i_rstn(i_rstn), .i_cmd_code(i_cmd_code), .i_wr_stb(i_wr_stb),
  .i_wr_data(i_wr_data), .i_rd_stb(i_rd_stb), .o_rd_valid(o_rd_valid), .o_wr_ack(o_wr_ack),
  .o_cmd_err(o_cmd_err), .o_sys_setup(o_sys_setup), .o_cml_termination(o_cml_termination),
  .o_monitor_diode_polarity(o_monitor_diode_polarity), .o_ext_temp_sel(o_ext_temp_sel),
  .o_apc_mode(o_apc_mode), .o_host_control(o_host_control), .o_tx_enable(o_tx_enable),
  .o_hs_amp_off(o_hs_amp_off), .o_load_start(o_load_start), .o_load_done(o_load_done));

`default_nettype wire
